/* File: rtl/itbt_pkg.sv */
/*
 * Package of the interval and time base timer: register addresses, field positions,
 * reset values, prescaler tap widths, power mode codes and the carrier structs.
 * Assumes an 8-bit register port with 16-bit addresses and a 125 MHz system clock.
 */
package itbt_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [15:0] ITBT_ADDR_MODE     = 16'hFFB0; // timer_mode_select
    localparam logic [15:0] ITBT_ADDR_COUNT    = 16'hFFB1; // timer_count_value
    localparam logic [15:0] ITBT_ADDR_CKSTP    = 16'hFFFA; // peripheral_clock_stop_one
    localparam logic [15:0] ITBT_ADDR_IRQ_STAT = 16'hFFC0; // sticky overflow status, write one to clear
    localparam logic [15:0] ITBT_ADDR_IRQ_MASK = 16'hFFC1; // overflow interrupt enable

    // ****************************************
    // field positions and fixed read bits
    // ****************************************
    localparam int          ITBT_STBY_BIT    = 0;       // timer_standby_release
    localparam int          ITBT_TB_BIT      = 3;       // time_base_mode_bit
    localparam int          ITBT_OVF_BIT     = 0;       // overflow_request_flag in status and mask
    localparam logic [7:0]  ITBT_MODE_FIXED  = 8'hF0;   // bits 7..4 of mode read as one
    localparam logic [7:0]  ITBT_CKSTP_FIXED = 8'hC0;   // bits 7..6 of clock stop read as one
    localparam logic [3:0]  ITBT_SEL_CLEAR   = 4'hC;    // upper select pair 11 holds counter cleared
    localparam logic [7:0]  ITBT_CNT_MAX     = 8'hFF;   // last count before overflow

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0]  ITBT_SEL_RST    = 4'h0;
    localparam logic [7:0]  ITBT_CNT_RST    = 8'h00;
    localparam logic [5:0]  ITBT_CKSTP_RST  = 6'h3F;
    localparam logic [7:0]  ITBT_RDATA_RST  = 8'h00;

    // ****************************************
    // prescaler taps (log2 of divide ratio)
    // ****************************************
    localparam int ITBT_PSS_W    = 13;                 // system prescaler, up to /8192
    localparam int ITBT_PSW_W    = 7;                  // subclock prescaler, up to /128
    localparam int ITBT_SUB_HZ   = 32768;              // subclock rate
    localparam int ITBT_CNT_SPAN = 256;                // counter inputs per overflow
    // time base period 1 s, 0.5 s, 0.25 s, 0.03125 s as subclock divisors
    localparam int ITBT_TB_DIV_1S    = ITBT_SUB_HZ / ITBT_CNT_SPAN;
    localparam int ITBT_TB_DIV_HALF  = ITBT_SUB_HZ / 2 / ITBT_CNT_SPAN;
    localparam int ITBT_TB_DIV_QUART = ITBT_SUB_HZ / 4 / ITBT_CNT_SPAN;
    localparam int ITBT_TB_DIV_32TH  = ITBT_SUB_HZ / 32 / ITBT_CNT_SPAN;

    // ****************************************
    // power modes, one-hot
    // ****************************************
    typedef enum logic [5:0] {
        ITBT_PM_ACTIVE    = 6'h01,
        ITBT_PM_SLEEP     = 6'h02,
        ITBT_PM_WATCH     = 6'h04,
        ITBT_PM_SUBACTIVE = 6'h08,
        ITBT_PM_SUBSLEEP  = 6'h10,
        ITBT_PM_STANDBY   = 6'h20
    } itbt_pmode_t;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [15:0] addr;   // register address
        logic [7:0]  wdata;  // write data
        logic        wr;     // write strobe
        logic        rd;     // read strobe
    } itbt_bus_t;

    typedef struct packed {
        logic [3:0]            sel;      // clock select field of mode register
        logic [7:0]            cnt;      // counter value
        logic [5:0]            ckstp;    // clock stop bits 5..0
        logic                  ovf_flag; // sticky overflow request
        logic                  ovf_en;   // overflow interrupt enable
        logic [ITBT_PSS_W-1:0] system_clock_prescaler;      // system_clock_prescaler
        logic [ITBT_PSW_W-1:0] subclock_prescaler;      // subclock_prescaler
        logic                  sub_s1;   // subclock synchroniser stage one
        logic                  sub_s2;   // subclock synchroniser stage two
        logic                  sub_s3;   // edge detect history
        logic [7:0]            rdata;    // registered read data
    } itbt_state_t;

    localparam itbt_state_t ITBT_STATE_RST = '{
        sel: ITBT_SEL_RST, cnt: ITBT_CNT_RST, ckstp: ITBT_CKSTP_RST,
        ovf_flag: 1'b0, ovf_en: 1'b0, system_clock_prescaler: '0, subclock_prescaler: '0,
        sub_s1: 1'b0, sub_s2: 1'b0, sub_s3: 1'b0, rdata: ITBT_RDATA_RST
    };

endpackage : itbt_pkg

/* File: rtl/itbt_timer.sv */
/*
 * Interval and time base timer: 8-bit up counter fed by a system clock prescaler
 * or by a synchronised 32.768 kHz subclock prescaler, with overflow interrupt.
 * Assumes a plain register port on the system clock, a power mode code from logic
 * on the same clock, and a free running subclock arriving on a pin.
 */
`timescale 1ns/10ps
`default_nettype none

module itbt_timer
    import itbt_pkg::*;
(
    input  wire logic        sys_clk_in,   // 125 MHz system clock
    input  wire logic        rst_in,       // synchronous reset, active high
    input  wire itbt_bus_t   bus_in,       // register request
    output logic [7:0]       rdata_out,    // read data, cycle after read strobe
    input  wire itbt_pmode_t pmode_in,     // chip power mode, same clock domain
    input  wire logic        sub_clk_in,   // 32.768 kHz subclock pin
    output logic             irq_out       // overflow interrupt, level
);

    // ****************************************
    // state and helpers
    // ****************************************
    itbt_state_t st_q;          // all registered state
    itbt_state_t st_d;          // next state
    logic        sub_edge;      // rising subclock edge, system clock domain
    logic        clear_hold;    // counter and subclock prescaler held cleared
    logic        intv_run;      // power mode lets interval counting run
    logic        tb_run;        // power mode lets time base counting run
    logic        mode_wr_ok;    // power mode lets the mode register take writes
    logic        count_en;      // counter may advance this cycle
    logic        tick;          // selected input clock pulse
    logic        ovf;           // counter overflows this cycle

    // true when the low k bits of v are all ones, i.e. a /2^k tap fires
    function automatic logic tap_hit(input logic [ITBT_PSS_W-1:0] v, input int k);
        logic [ITBT_PSS_W-1:0] m;
        m = ITBT_PSS_W'((1 << k) - 1);
        return (v & m) == m;
    endfunction : tap_hit

    // ****************************************
    // power mode decode
    // ****************************************
    // every mode but standby keeps the subclock path alive; standby stops everything
    always_comb
    begin
        intv_run   = 1'b0;
        tb_run     = 1'b0;
        mode_wr_ok = 1'b0;
        case (pmode_in)
            ITBT_PM_ACTIVE:
            begin
                intv_run   = 1'b1;
                tb_run     = 1'b1;
                mode_wr_ok = 1'b1;
            end
            ITBT_PM_SLEEP:     // register retained, counter runs
            begin
                intv_run = 1'b1;
                tb_run   = 1'b1;
            end
            ITBT_PM_WATCH,
            ITBT_PM_SUBSLEEP:  // only the time base keeps going
            begin
                tb_run = 1'b1;
            end
            ITBT_PM_SUBACTIVE: // time base runs and the CPU can write
            begin
                tb_run     = 1'b1;
                mode_wr_ok = 1'b1;
            end
            default:           // standby or an illegal code: everything halted
            begin
                intv_run   = 1'b0;
                tb_run     = 1'b0;
                mode_wr_ok = 1'b0;
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_d = st_q;

        // subclock synchroniser; stage one feeds stage two only
        st_d.sub_s1 = sub_clk_in;
        st_d.sub_s2 = st_q.sub_s1;
        st_d.sub_s3 = st_q.sub_s2;
        sub_edge    = st_q.sub_s2 & ~st_q.sub_s3;

        // codes 1100..1111 all clear, the undefined ones included
        clear_hold = (st_q.sel[3:2] == ITBT_SEL_CLEAR[3:2]);

        // system prescaler runs freely; taps are its carry points.
        // trade-off: one shared divider instead of eight, so the first
        // tick after a select change may come anywhere inside its period.
        st_d.system_clock_prescaler = st_q.system_clock_prescaler + ITBT_PSS_W'(1);

        // subclock prescaler advances on each synchronised edge while the standby bit and tb_run allow
        if (clear_hold)
        begin
            st_d.subclock_prescaler = '0;
        end
        else if (sub_edge && st_q.ckstp[ITBT_STBY_BIT] && tb_run)
        begin
            st_d.subclock_prescaler = st_q.subclock_prescaler + ITBT_PSW_W'(1);
        end

        // input clock select
        case (st_q.sel)
            4'h0:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(8192));
            4'h1:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(4096));
            4'h2:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(2048));
            4'h3:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(512));
            4'h4:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(256));
            4'h5:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(128));
            4'h6:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(32));
            4'h7:    tick = tap_hit(st_q.system_clock_prescaler, $clog2(8));
            4'h8:    tick = sub_edge & tap_hit({6'h00, st_q.subclock_prescaler}, $clog2(ITBT_TB_DIV_1S));
            4'h9:    tick = sub_edge & tap_hit({6'h00, st_q.subclock_prescaler}, $clog2(ITBT_TB_DIV_HALF));
            4'hA:    tick = sub_edge & tap_hit({6'h00, st_q.subclock_prescaler}, $clog2(ITBT_TB_DIV_QUART));
            4'hB:    tick = sub_edge & tap_hit({6'h00, st_q.subclock_prescaler}, $clog2(ITBT_TB_DIV_32TH));
            default: tick = 1'b0;                                   // cleared codes never count
        endcase

        // counter runs only where the power mode and standby bit allow it
        count_en = st_q.ckstp[ITBT_STBY_BIT] && !clear_hold &&
                   (st_q.sel[ITBT_TB_BIT] ? tb_run : intv_run);
        ovf      = count_en && tick && (st_q.cnt == ITBT_CNT_MAX);

        if (clear_hold)
        begin
            st_d.cnt = ITBT_CNT_RST;
        end
        else if (count_en && tick)
        begin
            st_d.cnt = st_q.cnt + 8'h01;                            // (FF wraps to 00)
        end

        // ****************************************
        // register writes
        // ****************************************
        if (bus_in.wr)
        begin
            case (bus_in.addr)
                ITBT_ADDR_MODE:
                begin
                    // bits 7..5 are expected zero and bit 4 is fixed: neither is stored
                    if (mode_wr_ok)
                    begin
                        st_d.sel[2:0] = bus_in.wdata[2:0];
                        if (st_q.ckstp[ITBT_STBY_BIT])
                        begin
                            st_d.sel[ITBT_TB_BIT] = bus_in.wdata[ITBT_TB_BIT];
                        end
                    end
                end
                ITBT_ADDR_CKSTP:
                begin
                    st_d.ckstp = bus_in.wdata[5:0];
                end
                ITBT_ADDR_IRQ_STAT:
                begin
                    if (bus_in.wdata[ITBT_OVF_BIT])
                    begin
                        st_d.ovf_flag = 1'b0;
                    end
                end
                ITBT_ADDR_IRQ_MASK:
                begin
                    st_d.ovf_en = bus_in.wdata[ITBT_OVF_BIT];
                end
                default:
                begin
                    st_d.ovf_en = st_q.ovf_en;                      // count register and others ignore writes
                end
            endcase
        end

        // overflow sets after any clear so a same-cycle event is kept
        if (ovf)
        begin
            st_d.ovf_flag = 1'b1;
        end

        // ****************************************
        // register reads
        // ****************************************
        st_d.rdata = 8'h00;
        if (bus_in.rd)
        begin
            case (bus_in.addr)
                ITBT_ADDR_MODE:     st_d.rdata = ITBT_MODE_FIXED | {4'h0, st_q.sel};
                ITBT_ADDR_COUNT:    st_d.rdata = (pmode_in == ITBT_PM_SUBACTIVE) ?
                                                 8'h00 : st_q.cnt;
                ITBT_ADDR_CKSTP:    st_d.rdata = ITBT_CKSTP_FIXED | {2'h0, st_q.ckstp};
                ITBT_ADDR_IRQ_STAT: st_d.rdata = {7'h00, st_q.ovf_flag};
                ITBT_ADDR_IRQ_MASK: st_d.rdata = {7'h00, st_q.ovf_en};
                default:            st_d.rdata = 8'h00;             // unmapped reads as zero
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // synchronous reset; the prescalers restart from zero too
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            st_q <= ITBT_STATE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_out = st_q.rdata;
    assign irq_out   = st_q.ovf_flag & st_q.ovf_en;

    // ****************************************
    // assertions
    // ****************************************
    a_clear_holds_zero: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (st_q.sel[3:2] == 2'b11) |=> (st_q.cnt == 8'h00) && (st_q.subclock_prescaler == '0))
        else $error("counter or prescaler not cleared under select 11");

    a_ovf_sets_flag: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (count_en && tick && st_q.cnt == 8'hFF) |=> st_q.ovf_flag)
        else $error("overflow did not set request flag");

    a_wrap_to_zero: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (count_en && tick && st_q.cnt == 8'hFF) |=> (st_q.cnt == 8'h00))
        else $error("counter did not wrap to zero");

    a_count_step_one: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (count_en && tick && st_q.cnt != 8'hFF) |=> (st_q.cnt == $past(st_q.cnt) + 8'h01))
        else $error("counter did not step by one");

    a_irq_gated_enable: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (!st_q.ovf_en || !st_q.ovf_flag) |-> !irq_out)
        else $error("interrupt raised without enable and flag");

    a_reset_clears_mode: assert property (
        @(posedge sys_clk_in)
        rst_in |=> (st_q.cnt == 8'h00) && (st_q.sel[3] == 1'b0) && st_q.ckstp[0])
        else $error("reset values wrong");

    a_sub_read_zero: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (bus_in.rd && bus_in.addr == ITBT_ADDR_COUNT && pmode_in == ITBT_PM_SUBACTIVE)
        |=> (rdata_out == 8'h00))
        else $error("counter readable in subactive");

    a_mode_bit4_one: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (bus_in.rd && bus_in.addr == ITBT_ADDR_MODE) |=> rdata_out[4])
        else $error("mode bit 4 not read as one");

    a_standby_freeze: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (!st_q.ckstp[0] && st_q.sel[3:2] != 2'b11) |=> $stable(st_q.cnt))
        else $error("counter moved in module standby");

    a_interval_halt: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (!st_q.sel[3] && !(pmode_in inside {ITBT_PM_ACTIVE, ITBT_PM_SLEEP})) |=> $stable(st_q.cnt))
        else $error("interval counter ran outside active or sleep");

    a_mode_bit_lock: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (bus_in.wr && bus_in.addr == ITBT_ADDR_MODE && !st_q.ckstp[0]) |=> $stable(st_q.sel[3]))
        else $error("mode select bit changed while in module standby");

    // overflow and a clear in one cycle: the event must not be lost
    a_flag_set_wins: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (ovf && bus_in.wr && bus_in.addr == ITBT_ADDR_IRQ_STAT && bus_in.wdata[0]) |=> st_q.ovf_flag)
        else $error("overflow lost against a same cycle clear");

    // an enabled pending request must reach the pin
    a_irq_follows_flag: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (st_q.ovf_flag && st_q.ovf_en) |-> irq_out)
        else $error("interrupt missing with flag and enable set");

    // module standby also freezes the subclock prescaler
    a_psw_standby_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (!st_q.ckstp[0] && !clear_hold) |=> $stable(st_q.subclock_prescaler))
        else $error("subclock prescaler moved in module standby");

    // chip standby halts the time base as well
    a_tb_standby_halt: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (st_q.sel[3:2] == 2'b10 && pmode_in == ITBT_PM_STANDBY) |=> $stable(st_q.cnt))
        else $error("time base counted in standby");

    // mode register keeps its contents where the power mode forbids writes
    a_mode_retained: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (bus_in.wr && bus_in.addr == ITBT_ADDR_MODE && !mode_wr_ok) |=> $stable(st_q.sel))
        else $error("mode register changed while retained");

    // read data stand for one cycle only, then return to zero
    a_rdata_one_cycle: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !bus_in.rd |=> (rdata_out == 8'h00))
        else $error("read data stood without a read strobe");

    // outside the clearing codes the counter must not move in a cycle without an enabled selected tick
    a_single_step: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (!count_en || !tick) && !clear_hold |=> $stable(st_q.cnt))
        else $error("counter moved without a selected input clock");

endmodule : itbt_timer

`default_nettype wire

/* File: testbench/test_itbt_timer.sv */
/*
 * Self-checking bench of the interval and time base timer: register map, tick rates,
 * overflow interrupt, clearing codes, standby bit and power modes, with a small model.
 * Assumes itbt_pkg and itbt_timer compiled before it; the subclock is made from sys_clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module test_itbt_timer
    import itbt_pkg::*;
;
    // ****************************************
    // design ports and bench state
    // ****************************************
    logic        sys_clk_in;              // 125 MHz
    logic        rst_in;                  // synchronous, active high
    itbt_bus_t   bus_in;                  // register request
    logic [7:0]  rdata_out;               // read data
    itbt_pmode_t pmode_in;                // chip power mode
    logic        sub_clk_in = 1'b0;       // fast stand-in for the subclock
    logic        irq_out;                 // level interrupt
    int          fails;                   // mismatches
    int          num_checks;              // comparisons
    int          cyc = 0;                 // free cycle count
    int          t1;                      // first overflow cycle
    int          t2;                      // second overflow cycle
    logic        hi;                      // irq seen while masked, unknown kept
    logic [7:0]  v;                       // last read value
    logic [3:0]  m_sel;                   // model: clock select field
    logic [5:0]  m_ckstp;                 // model: clock stop bits
    int          ksys [8] = '{13, 12, 11, 9, 8, 7, 5, 3}; // log2 interval taps
    int          ksub [4] = '{7, 6, 5, 2};                // log2 time base taps

    itbt_timer u_itbt_timer (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .bus_in     (bus_in),
        .rdata_out  (rdata_out),
        .pmode_in   (pmode_in),
        .sub_clk_in (sub_clk_in),
        .irq_out    (irq_out)
    );

    // ****************************************
    // clocks
    // ****************************************
    // system clock, 8 ns period
    initial
    begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    // subclock at 1/8 of the system rate: far faster than real, keeps runs short
    always @(posedge sys_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3)
            sub_clk_in <= ~sub_clk_in;
    end

    // ****************************************
    // bus tasks and model
    // ****************************************
    // one-cycle write; returns on the edge after, so strobes never collide
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_in.addr  <= a;
        bus_in.wdata <= d;
        bus_in.wr    <= 1'b1;
        @(posedge sys_clk_in);
        bus_in.wr    <= 1'b0;
        if (a == ITBT_ADDR_MODE && (pmode_in == ITBT_PM_ACTIVE || pmode_in == ITBT_PM_SUBACTIVE))
            m_sel = m_ckstp[0] ? d[3:0] : {m_sel[3], d[2:0]};
        if (a == ITBT_ADDR_CKSTP)
            m_ckstp = d[5:0];
        @(posedge sys_clk_in);
    endtask : wr

    // one-cycle read; data taken in the single cycle it stands
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        bus_in.addr <= a;
        bus_in.rd   <= 1'b1;
        @(posedge sys_clk_in);
        bus_in.rd   <= 1'b0;
        @(posedge sys_clk_in);
        d = rdata_out;
    endtask : rd

    // model view of the readable registers; unmapped places read zero
    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        if (a == ITBT_ADDR_MODE)
            return ITBT_MODE_FIXED | {4'h0, m_sel};
        if (a == ITBT_ADDR_CKSTP)
            return ITBT_CKSTP_FIXED | {2'h0, m_ckstp};
        return 8'h00;
    endfunction : exp_rd

    // read and compare with the model
    task automatic rdm(input logic [15:0] a, input string nm);
        rd(a, v);
        `CHK(nm, exp_rd(a), v)
    endtask : rdm

    // count advance between two reads exactly len cycles apart
    task automatic span(input int len, input int ex, input string nm);
        logic [7:0] a;
        logic [7:0] b;
        rd(ITBT_ADDR_COUNT, a);
        repeat (len - 2) @(posedge sys_clk_in);
        rd(ITBT_ADDR_COUNT, b);
        `CHK(nm, ex[7:0], b - a)
    endtask : span

    // bounded wait for the interrupt level
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq_out !== 1'b1 && n < 2100)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        t = cyc;
        `CHK("irq rise", 1'b1, irq_out)
    endtask : wait_irq

    // ****************************************
    // verdict and watchdog
    // ****************************************
    task automatic wrap_up;
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // whole run is near 41k cycles; this cuts a hang short
    initial
    begin
        repeat (95000) @(posedge sys_clk_in);
        fails++;
        wrap_up();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        bus_in = '0;
        pmode_in = ITBT_PM_ACTIVE;
        rst_in = 1'b1;
        fails = 0;
        num_checks = 0;
        m_sel = 4'h0;
        m_ckstp = 6'h3F;
        void'($urandom(74418));
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        // reset values and fixed bits
        rdm(ITBT_ADDR_MODE, "mode reset");
        rdm(ITBT_ADDR_CKSTP, "ckstp reset");
        `CHK("irq reset", 1'b0, irq_out)
        wr(ITBT_ADDR_MODE, 8'h17);
        rdm(ITBT_ADDR_MODE, "bit4 fixed");
        // unmapped places: writes lost, reads zero
        for (int i = 0; i < 3; i++)
        begin
            t1 = 16'hFF00 + $urandom_range(0, 127);
            wr(t1[15:0], 8'($urandom));
            rdm(t1[15:0], "unmapped");
        end
        rdm(ITBT_ADDR_MODE, "mode kept");
        // interval taps, every code (code 0 comes after the second reset)
        for (int c = 1; c < 8; c++)
        begin
            wr(ITBT_ADDR_MODE, c[7:0]);
            repeat ($urandom_range(0, 7)) @(posedge sys_clk_in);
            span(2 << ksys[c], 2, "interval rate");
        end
        // clearing codes hold the counter at zero; count ignores writes
        for (int c = 12; c < 16; c++)
        begin
            wr(ITBT_ADDR_MODE, c[7:0]);
            wr(ITBT_ADDR_COUNT, 8'($urandom));
            repeat (20) @(posedge sys_clk_in);
            rd(ITBT_ADDR_COUNT, v);
            `CHK("held clear", 8'h00, v)
            rdm(ITBT_ADDR_MODE, "clear code");
        end
        // overflow from zero at /8, interrupt enabled, then period
        wr(ITBT_ADDR_IRQ_MASK, 8'h01);
        wr(ITBT_ADDR_MODE, 8'h07);
        wait_irq(t1);
        rd(ITBT_ADDR_IRQ_STAT, v);
        `CHK("flag set", 1'b1, v[ITBT_OVF_BIT])
        wr(ITBT_ADDR_IRQ_STAT, 8'h01);
        `CHK("irq cleared", 1'b0, irq_out)
        wait_irq(t2);
        `CHK("overflow period", 2048, t2 - t1)
        // masked: flag still set, no interrupt
        wr(ITBT_ADDR_IRQ_MASK, 8'h00);
        wr(ITBT_ADDR_IRQ_STAT, 8'h01);
        hi = 1'b0;
        repeat (2100)
        begin
            @(posedge sys_clk_in);
            hi = hi | irq_out;
        end
        `CHK("masked irq", 1'b0, hi)
        rd(ITBT_ADDR_IRQ_STAT, v);
        `CHK("masked flag", 1'b1, v[ITBT_OVF_BIT])
        // module standby halts and locks the mode bit
        wr(ITBT_ADDR_CKSTP, 8'h3E);
        rdm(ITBT_ADDR_CKSTP, "ckstp rw");
        span(64, 0, "standby halt");
        wr(ITBT_ADDR_MODE, 8'h0E);
        rdm(ITBT_ADDR_MODE, "mode bit locked");
        wr(ITBT_ADDR_CKSTP, 8'h3F);
        // time base periods through the synchroniser
        for (int c = 0; c < 4; c++)
        begin
            wr(ITBT_ADDR_MODE, 8'h08 | c[7:0]);
            rdm(ITBT_ADDR_MODE, "mode bit free");
            span(16 << ksub[c], 2, "time base rate");
        end
        // power modes with time base code 1011
        pmode_in <= ITBT_PM_WATCH;
        span(64, 2, "tb watch");
        pmode_in <= ITBT_PM_SUBSLEEP;
        span(64, 2, "tb subsleep");
        pmode_in <= ITBT_PM_SUBACTIVE;
        rd(ITBT_ADDR_COUNT, v);
        `CHK("subactive read", 8'h00, v)
        pmode_in <= ITBT_PM_STANDBY;
        span(64, 0, "tb standby");
        pmode_in <= ITBT_PM_SLEEP;
        wr(ITBT_ADDR_MODE, 8'h07);
        rdm(ITBT_ADDR_MODE, "mode retained");
        pmode_in <= ITBT_PM_ACTIVE;
        wr(ITBT_ADDR_MODE, 8'h07);
        pmode_in <= ITBT_PM_WATCH;
        span(64, 0, "interval watch");
        pmode_in <= ITBT_PM_SLEEP;
        span(64, 8, "interval sleep");
        // second reset in mid-run: counting restarts at /8192 unconfigured
        pmode_in <= ITBT_PM_ACTIVE;
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        m_sel = 4'h0;
        m_ckstp = 6'h3F;
        rdm(ITBT_ADDR_MODE, "mode rereset");
        rdm(ITBT_ADDR_CKSTP, "ckstp rereset");
        span(16384, 2, "count after reset");
        wrap_up();
    end

endmodule : test_itbt_timer
`default_nettype wire
